// [flash_defs.svh]
// opcodes, register bit positions, reset values and sizes of the flash front end
`ifndef FLASH_DEFS_SVH
`define FLASH_DEFS_SVH

// command opcodes
`define OP_WRITE_ENABLE       8'h06
`define OP_WRITE_STATUS       8'h01
`define OP_READ_STATUS        8'h05
`define OP_READ_CONFIG        8'h35
`define OP_LOCK_PROTECTION    8'h8D
`define OP_PROGRAM_SECURE_ID  8'hA5
`define OP_LOCK_SECURE_ID     8'h85
`define OP_ENTER_QUAD         8'h38
`define OP_EXIT_QUAD          8'hFF
`define OP_RESET_ENABLE       8'h66
`define OP_RESET_GO           8'h99

// status byte bit positions
`define ST_BUSY               0
`define ST_WEL                1
`define ST_PLVL_LSB           2
`define ST_PLVL_MSB           3
`define ST_PLOCK              7

// config byte bit positions
`define CF_QIO                1
`define CF_VLOCK              3
`define CF_PIN_PROT           7

// reset values
`define PLVL_RST              2'h3
`define PINS_IDLE             8'hFF

// frame bit counts
`define BITS_BYTE             5'h08
`define BITS_ADDR             5'h18

// security id area, in bytes
`define SID_BYTES             24'h000800
`define SID_FACTORY_BYTES     24'h000010

`endif

// [flash_pkg.sv]
// types shared by the flash front end
package flash_pkg;

  typedef enum logic [4:0] {
    PH_CMD  = 5'h01,
    PH_ADDR = 5'h02,
    PH_DATA = 5'h04,
    PH_READ = 5'h08,
    PH_SKIP = 5'h10
  } phase_e;

  typedef struct packed {
    logic       sck;
    logic       cs_n;
    logic       pause_n;
    logic       write_protect_n;
    logic [3:0] dq;
  } pins_s;

  typedef struct packed {
    phase_e      phase;
    logic [7:0]  shift;
    logic [4:0]  nbits;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [1:0]  wbytes;
    logic [7:0]  rdata;
    logic        sck_prev;
    logic        cs_prev;
    logic        paused;
    logic        out_on;
    logic        loaded;
    logic        quad;
    logic        wel;
    logic        busy;
    logic [1:0]  plvl;
    logic        plock;
    logic        qio;
    logic        vlock;
    logic        pin_prot;
    logic        sid_lock;
    logic        rst_armed;
    logic [3:0]  dq_out;
    logic [3:0]  dq_oe;
    logic        wr_start;
    logic        pin_prot_wr;
    logic        sid_lock_wr;
    logic        sid_prog;
    logic [10:0] sid_addr;
    logic [7:0]  sid_data;
  } state_s;

endpackage : flash_pkg

// [pin_sync.sv]
// two-flop synchroniser for the serial link pins
`timescale 1ns/100ps
module pin_sync #(
  parameter int         WIDTH   = 8,
  parameter [WIDTH-1:0] RST_VAL = '1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : pin_sync

// [protect_eval.sv]
// write-status and security id permission decisions
`timescale 1ns/100ps
`include "flash_defs.svh"
module protect_eval (
  // mode and lock state
  input  wire logic        quad,
  input  wire logic        qio,
  input  wire logic        pin_prot,
  input  wire logic        write_protect_n,
  input  wire logic        vlock,
  input  wire logic        plock,
  input  wire logic        sid_lock,
  input  wire logic [23:0] addr,
  // permissions
  output logic             bp_ok,
  output logic             cfg_ok,
  output logic             sid_ok
);
  // the pin is a data line in quad protocol and is overruled by the config bit
  function automatic logic pin_lock_of(input logic q, input logic c, input logic e,
                                       input logic wn);
    return !q && !c && e && !wn;                     // RULE_09 RULE_10 RULE_12
  endfunction : pin_lock_of

  always_comb begin
    bp_ok  = !vlock && !(pin_lock_of(quad, qio, pin_prot, write_protect_n) && plock); // RULE_15 RULE_14 RULE_25
    cfg_ok = !pin_lock_of(quad, qio, pin_prot, write_protect_n);                      // RULE_16 RULE_13
    sid_ok = !sid_lock && addr >= `SID_FACTORY_BYTES && addr < `SID_BYTES;            // RULE_17 RULE_18
  end
endmodule : protect_eval

// [flash_front.sv]
// serial flash bus front end: protocol, pause and protection logic
// Operation
// RULE_01: power-up in single-line protocol, multi-I/O accepted
// RULE_02: a command switches to four-line protocol
// RULE_03: clock idle low or high both accepted
// RULE_04: sample on rising edge, drive after falling
// RULE_05: block protection set after power-on
// RULE_06: lock command sets volatile lock, freezing protection
// RULE_07: lock command needs preceding write enable
// RULE_08: volatile lock cleared only by reset; readable
// RULE_09: protect pin only in single/dual mode, config zero
// RULE_10: pin ignored while pin protect enable zero
// RULE_11: pin protect enable nonvolatile, default zero
// RULE_12: quad config bit one overrides pin and enable
// RULE_13: pin guards lock bit and config only
// RULE_14: lock bit gates level writes under pin lock
// RULE_15: level write refused by volatile lock or pin lock; code refuses under pin lock only while the lock bit is set
// RULE_16: config write refused exactly under pin lock
// RULE_17: factory id segment never user writable
// RULE_18: id lock command blocks later id writes
// RULE_19: erase never touches the id area
// RULE_20: pause disabled in four-line protocol
// RULE_21: pause starts and ends at clock low
// RULE_22: paused: output released, inputs ignored
// RULE_23: select high during pause resets logic
// RULE_24: quad config bit cleared by software reset
// RULE_25: lock bit makes level bits read-only; code does so only under pin lock
// RULE_26: refused write-status starts no internal write
`timescale 1ns/100ps
`include "flash_defs.svh"
module flash_front
  import flash_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // serial link pins
  input  wire logic        serial_clk,
  input  wire logic        cs_n,
  input  wire logic        pause_n,
  input  wire logic        write_protect_n,
  input  wire logic [3:0]  quad_data_lines_in,
  output logic      [3:0]  quad_data_lines_out,
  output logic      [3:0]  quad_data_lines_oe,
  // nonvolatile store and array side
  input  wire logic        pin_protect_enable_nv,
  input  wire logic        sid_lock_nv,
  input  wire logic        array_busy,
  // state and requests
  output logic      [7:0]  status_byte,
  output logic      [7:0]  config_byte,
  output logic             quad_serial_protocol,
  output logic             paused,
  output logic             write_start,
  output logic             pin_protect_enable_wr,
  output logic             sid_lock_wr,
  output logic             sid_prog,
  output logic      [10:0] sid_addr,
  output logic      [7:0]  sid_data
);
  localparam state_s STATE_INIT = '{phase: PH_CMD, plvl: `PLVL_RST, sck_prev: 1'b1,
                                    cs_prev: 1'b1, default: '0};

  pins_s  pins;
  state_s state_reg;
  state_s state_next;
  logic   bp_ok;
  logic   cfg_ok;
  logic   sid_ok;
  logic   sck_rise;
  logic   sck_fall;
  logic   cs_rise;

  ////////////////////////////////////////////////////////////////////////////////
  pin_sync #(
    .WIDTH   (8),
    .RST_VAL (`PINS_IDLE)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({serial_clk, cs_n, pause_n, write_protect_n, quad_data_lines_in}),
    .sync_out (pins)
  );

  protect_eval u_prot (
    .quad            (state_reg.quad),
    .qio             (state_reg.qio),
    .pin_prot        (state_reg.pin_prot),
    .write_protect_n (pins.write_protect_n),
    .vlock           (state_reg.vlock),
    .plock           (state_reg.plock),
    .sid_lock        (state_reg.sid_lock),
    .addr            (state_reg.addr),
    .bp_ok           (bp_ok),
    .cfg_ok          (cfg_ok),
    .sid_ok          (sid_ok)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] status_of(input state_s s);
    logic [7:0] v;
    v = 8'h00;
    v[`ST_BUSY]     = s.busy;
    v[`ST_WEL]      = s.wel;
    v[`ST_PLVL_LSB] = s.plvl[0];
    v[`ST_PLVL_MSB] = s.plvl[1];
    v[`ST_PLOCK]    = s.plock;
    return v;
  endfunction : status_of

  function automatic logic [7:0] config_of(input state_s s);
    logic [7:0] v;
    v = 8'h00;
    v[`CF_QIO]      = s.qio;
    v[`CF_VLOCK]    = s.vlock;
    v[`CF_PIN_PROT] = s.pin_prot;
    return v;
  endfunction : config_of

  function automatic phase_e phase_of(input logic [7:0] op);
    case (op)
      `OP_WRITE_STATUS:      return PH_DATA;
      `OP_PROGRAM_SECURE_ID: return PH_ADDR;
      `OP_READ_STATUS:       return PH_READ;
      `OP_READ_CONFIG:       return PH_READ;
      default:               return PH_SKIP;
    endcase
  endfunction : phase_of

  // both clock idle levels work: only edges seen while selected matter
  assign sck_rise = pins.sck && !state_reg.sck_prev;   // RULE_03
  assign sck_fall = !pins.sck && state_reg.sck_prev;
  assign cs_rise  = pins.cs_n && !state_reg.cs_prev;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_s     r;
    logic [7:0] byte_in;
    logic [4:0] step;
    logic [4:0] cnt;
    logic [3:0] mask;
    r          = state_reg;
    state_next = r;
    step       = r.quad ? 5'h04 : 5'h01;
    cnt        = r.nbits + step;
    byte_in    = r.quad ? {r.shift[3:0], pins.dq} : {r.shift[6:0], pins.dq[0]}; // RULE_02
    mask       = r.quad ? 4'hF : 4'h2;
    state_next.sck_prev    = pins.sck;
    state_next.cs_prev     = pins.cs_n;
    state_next.busy        = array_busy;
    state_next.wr_start    = 1'b0;
    state_next.pin_prot_wr = 1'b0;
    state_next.sid_lock_wr = 1'b0;
    state_next.sid_prog    = 1'b0;
    // nonvolatile bits are caught once, after reset release
    if (!r.loaded) begin
      state_next.loaded   = 1'b1;
      state_next.pin_prot = pin_protect_enable_nv;   // RULE_11
      state_next.sid_lock = sid_lock_nv;
    end
    // frame end: commands act on deselect, never if it ends a pause
    if (cs_rise && !r.paused) begin                  // RULE_23
      state_next.rst_armed = 1'b0;
      if (r.phase == PH_SKIP && r.nbits == 5'h00) begin
        case (r.opcode)
          `OP_WRITE_ENABLE: state_next.wel = 1'b1;
          `OP_LOCK_PROTECTION: begin
            if (r.wel) begin                         // RULE_07
              state_next.vlock = 1'b1;               // RULE_06
              state_next.wel   = 1'b0;
            end
          end
          `OP_LOCK_SECURE_ID: begin
            if (r.wel) begin
              state_next.sid_lock    = 1'b1;         // RULE_18
              state_next.sid_lock_wr = 1'b1;
              state_next.wel         = 1'b0;
            end
          end
          `OP_ENTER_QUAD:   state_next.quad = 1'b1;  // RULE_02
          `OP_EXIT_QUAD:    state_next.quad = 1'b0;
          `OP_RESET_ENABLE: state_next.rst_armed = 1'b1;
          `OP_RESET_GO: begin
            if (r.rst_armed) begin
              state_next.quad = 1'b0;
              state_next.qio  = 1'b0;                // RULE_24
              state_next.wel  = 1'b0;
            end
          end
          default: ;
        endcase
      end
      // the decision uses the pin level at frame end; a later pin change cannot
      // reach a write already started
      if (r.phase == PH_DATA && r.opcode == `OP_WRITE_STATUS && r.wbytes != 2'h0 &&
          r.nbits == 5'h00 && r.wel) begin           // RULE_13
        state_next.wel = 1'b0;
        if (bp_ok) begin
          state_next.plvl[0] = r.wdata[{r.wbytes[1], 3'h0} + `ST_PLVL_LSB];  // RULE_15 RULE_25
          state_next.plvl[1] = r.wdata[{r.wbytes[1], 3'h0} + `ST_PLVL_MSB];
        end
        if (cfg_ok) begin
          state_next.plock = r.wdata[{r.wbytes[1], 3'h0} + `ST_PLOCK];       // RULE_14
        end
        if (cfg_ok && r.wbytes[1]) begin             // RULE_16
          state_next.qio         = r.wdata[`CF_QIO];
          state_next.pin_prot    = r.wdata[`CF_PIN_PROT];
          state_next.pin_prot_wr = r.wdata[`CF_PIN_PROT] != r.pin_prot;
        end
        state_next.wr_start = bp_ok || cfg_ok;       // RULE_26
      end
      if (r.phase == PH_DATA && r.opcode == `OP_PROGRAM_SECURE_ID) begin
        state_next.wel = 1'b0;
      end
    end
    if (pins.cs_n) begin
      state_next.phase  = PH_CMD;
      state_next.nbits  = 5'h00;
      state_next.wbytes = 2'h0;
      state_next.paused = 1'b0;                      // RULE_23
      state_next.out_on = 1'b0;
    end else begin
      // pause changes only while the clock is low; the next level seen wins
      if (!r.quad && !pins.sck) begin                // RULE_20
        state_next.paused = !pins.pause_n;           // RULE_21
      end
      if (!r.paused && sck_rise) begin               // RULE_22 RULE_04
        state_next.shift = byte_in;
        state_next.nbits = cnt;
        unique case (r.phase)
          PH_CMD: begin
            if (cnt == `BITS_BYTE) begin
              state_next.opcode = byte_in;
              state_next.nbits  = 5'h00;
              state_next.phase  = phase_of(byte_in);
              state_next.addr   = 24'h000000;
              state_next.rdata  = (byte_in == `OP_READ_CONFIG) ? config_of(r) : status_of(r);
            end
          end
          PH_ADDR: begin
            state_next.addr = r.quad ? {r.addr[19:0], pins.dq} : {r.addr[22:0], pins.dq[0]};
            if (cnt == `BITS_ADDR) begin
              state_next.nbits = 5'h00;
              state_next.phase = PH_DATA;
            end
          end
          PH_DATA: begin
            if (cnt == `BITS_BYTE) begin
              state_next.nbits = 5'h00;
              if (r.opcode == `OP_WRITE_STATUS) begin
                state_next.wdata  = {r.wdata[7:0], byte_in};
                state_next.wbytes = (r.wbytes == 2'h2) ? 2'h2 : r.wbytes + 2'h1;
              end else begin
                // only the program path writes the id area; no erase reaches it
                state_next.sid_prog = r.wel && sid_ok;      // RULE_17 RULE_18 RULE_19
                state_next.sid_addr = r.addr[10:0];
                state_next.sid_data = byte_in;
                state_next.addr     = r.addr + 24'h000001;
              end
            end
          end
          PH_READ: state_next.nbits = 5'h00;
          PH_SKIP: state_next.nbits = 5'h01;
        endcase
      end
      // output changes after the falling edge; the byte repeats by rotation
      if (!r.paused && sck_fall && r.phase == PH_READ) begin // RULE_04
        state_next.out_on = 1'b1;
        state_next.dq_out = r.quad ? r.rdata[7:4] : {2'h0, r.rdata[7], 1'b0};
        state_next.rdata  = r.quad ? {r.rdata[3:0], r.rdata[7:4]} : {r.rdata[6:0], r.rdata[7]};
      end
    end
    mask = state_next.quad ? 4'hF : 4'h2;
    state_next.dq_oe = (state_next.out_on && !state_next.paused && !pins.cs_n) ? mask : 4'h0; // RULE_22
  end

  // power-on: single-line protocol, protection levels set, no volatile lock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= STATE_INIT;                       // RULE_01 RULE_05 RULE_08
    end else begin
      state_reg <= state_next;
    end
  end

  assign quad_data_lines_out   = state_reg.dq_out;
  assign quad_data_lines_oe    = state_reg.dq_oe;
  assign status_byte           = status_of(state_reg);
  assign config_byte           = config_of(state_reg);   // RULE_08
  assign quad_serial_protocol  = state_reg.quad;
  assign paused                = state_reg.paused;
  assign write_start           = state_reg.wr_start;
  assign pin_protect_enable_wr = state_reg.pin_prot_wr;
  assign sid_lock_wr           = state_reg.sid_lock_wr;
  assign sid_prog              = state_reg.sid_prog;
  assign sid_addr              = state_reg.sid_addr;
  assign sid_data              = state_reg.sid_data;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_status_exec;
    cs_rise && !state_reg.paused && state_reg.phase == PH_DATA && state_reg.wel &&
    state_reg.opcode == `OP_WRITE_STATUS && state_reg.wbytes != 2'h0 && state_reg.nbits == 5'h00;
  endsequence
  sequence s_lock_exec;
    cs_rise && !state_reg.paused && state_reg.phase == PH_SKIP && state_reg.nbits == 5'h00 &&
    state_reg.opcode == `OP_LOCK_PROTECTION && state_reg.wel;
  endsequence
  sequence s_pause_req;
    !pins.cs_n && !state_reg.quad && !pins.pause_n && !pins.sck;
  endsequence

  property p_boot_single;
    !state_reg.loaded |-> !state_reg.quad && state_reg.plvl == `PLVL_RST;
  endproperty
  a_boot_single: assert property (p_boot_single)         // RULE_01
    else $error("not single-line or unprotected after reset");

  property p_lock_sets;
    s_lock_exec |=> state_reg.vlock && !state_reg.wel;
  endproperty
  a_lock_sets: assert property (p_lock_sets)             // RULE_06
    else $error("lock command did not set volatile lock");

  property p_lock_needs_wel;
    !state_reg.vlock && !state_reg.wel |=> !state_reg.vlock;
  endproperty
  a_lock_needs_wel: assert property (p_lock_needs_wel)   // RULE_07
    else $error("volatile lock set without write enable");

  property p_lock_sticky;
    state_reg.vlock |=> state_reg.vlock [*8];
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)         // RULE_08
    else $error("volatile lock cleared without reset");

  property p_level_refused;
    s_status_exec ##0 !bp_ok |=> $stable(state_reg.plvl) [*2];
  endproperty
  a_level_refused: assert property (p_level_refused)     // RULE_15
    else $error("refused level write changed the level");

  property p_config_refused;
    s_status_exec ##0 !cfg_ok |=> $stable(state_reg.qio) && $stable(state_reg.pin_prot);
  endproperty
  a_config_refused: assert property (p_config_refused)   // RULE_16
    else $error("refused config write changed config");

  property p_no_start;
    s_status_exec ##0 (!bp_ok && !cfg_ok) |=> !write_start;
  endproperty
  a_no_start: assert property (p_no_start)               // RULE_26
    else $error("refused write-status started a write");

  property p_factory_safe;
    sid_prog |-> sid_addr >= 11'h010 && !$past(state_reg.sid_lock);
  endproperty
  a_factory_safe: assert property (p_factory_safe)       // RULE_17
    else $error("id write to factory segment or locked area");

  property p_pause_enter;
    s_pause_req ##1 !pins.cs_n |-> state_reg.paused;
  endproperty
  a_pause_enter: assert property (p_pause_enter)         // RULE_21
    else $error("pause not entered at clock low");

  property p_pause_hiz;
    paused |-> quad_data_lines_oe == 4'h0 && !state_reg.quad;
  endproperty
  a_pause_hiz: assert property (p_pause_hiz)             // RULE_22
    else $error("output driven or quad while paused");

  property p_quad_drive;
    !state_reg.paused && sck_fall && !pins.cs_n && state_reg.quad && state_reg.phase == PH_READ
    |=> quad_data_lines_oe == 4'hF ##1 quad_data_lines_oe != 4'h2;
  endproperty
  a_quad_drive: assert property (p_quad_drive)           // RULE_04
    else $error("quad read not driven on all four lines");
endmodule : flash_front

// [bus_host.sv]
// serial bus host model that frames commands to the flash front end
`timescale 1ns/100ps
module bus_host (
  // clock and bus style
  input  wire logic       clk,
  input  wire logic       mode3,
  input  wire logic       quad,
  // device pins
  input  wire logic [3:0] dq_from_dev,
  output logic            sck,
  output logic            cs_n,
  output logic      [3:0] dq
);
  logic [7:0] rx;
  ////////////////////////////////////////
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    dq   = 4'hF;
    rx   = 8'h00;
  end

  task automatic select(input logic v);
    @(posedge clk);
    cs_n <= v;
  endtask : select

  // sends the top nb bytes of d; rx keeps the last byte seen
  task automatic frame(input logic [47:0] d, input int nb);
    int n;
    // the bench sets the mode inputs at an edge, so read them only after the next one
    @(posedge clk);
    n = quad ? nb * 2 : nb * 8;
    sck <= mode3;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (n) begin
      @(posedge clk);
      sck <= 1'b0;
      dq  <= quad ? d[47:44] : {3'h7, d[47]};
      d = quad ? d << 4 : d << 1;
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      // sampled late in the high phase, well after the device output settles
      repeat (3) @(posedge clk);
      rx = quad ? {rx[3:0], dq_from_dev} : {rx[6:0], dq_from_dev[1]};
    end
    @(posedge clk);
    cs_n <= 1'b1;
    dq   <= ~dq;
    @(posedge clk);
    sck <= mode3;
    repeat (8) @(posedge clk);
  endtask : frame
endmodule : bus_host

// [tb.sv]
// self-checking bench for the flash front end
`timescale 1ns/100ps
`include "flash_defs.svh"
module tb;
  logic        clk, rst_n, pause_n, wp_n, mode3, quad, busy, ppe_nv, sidl_nv;
  logic        sck, cs_n, qsp, paused, ws, ppe_wr, sl_wr, sp;
  logic [3:0]  host_dq, dq_wire, dq_out, dq_oe;
  logic [7:0]  st, cf, sdat;
  logic [10:0] sadr;
  logic [15:0] prev;
  int          num_errors, checked, ws_n, sp_n, cyc, n0;
  localparam logic [32:0] ROWS [5] = '{{1'b0, 32'h8C808C80}, {1'b0, 32'h00008C80},
    {1'b1, 32'h00820082}, {1'b0, 32'h0C800C80}, {1'b0, 32'h00000080}};
  localparam logic [23:0] SIDS [4] = '{24'h000010, 24'h00000F, 24'h0007FF, 24'h000020};
  ////////////////////////////////////////
  assign dq_wire = (dq_oe & dq_out) | (~dq_oe & host_dq);

  flash_front flash_front_i (.clk(clk), .rst_n(rst_n), .serial_clk(sck), .cs_n(cs_n),
    .pause_n(pause_n), .write_protect_n(wp_n), .quad_data_lines_in(dq_wire),
    .quad_data_lines_out(dq_out), .quad_data_lines_oe(dq_oe),
    .pin_protect_enable_nv(ppe_nv), .sid_lock_nv(sidl_nv), .array_busy(busy),
    .status_byte(st), .config_byte(cf), .quad_serial_protocol(qsp), .paused(paused),
    .write_start(ws), .pin_protect_enable_wr(ppe_wr), .sid_lock_wr(sl_wr),
    .sid_prog(sp), .sid_addr(sadr), .sid_data(sdat));

  bus_host bus_host_i (.clk(clk), .mode3(mode3), .quad(quad), .dq_from_dev(dq_wire),
    .sck(sck), .cs_n(cs_n), .dq(host_dq));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // pulse counters, nonvolatile store and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ws === 1'b1) ws_n <= ws_n + 1;
    if (sp === 1'b1) sp_n <= sp_n + 1;
    if (ppe_wr === 1'b1) ppe_nv <= cf[7];
    if (sl_wr === 1'b1) sidl_nv <= 1'b1;
    if (cyc == 60000) begin
      num_errors = num_errors + 1;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk

  task automatic cmd(input logic [7:0] op);
    bus_host_i.frame({op, 40'h0}, 1);
  endtask : cmd

  task automatic write_status_cmd(input logic [15:0] v);
    cmd(`OP_WRITE_ENABLE);
    bus_host_i.frame({`OP_WRITE_STATUS, v, 24'h0}, 3);
  endtask : write_status_cmd

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  initial begin
    {rst_n, mode3, quad, busy, ppe_nv, sidl_nv} = 6'h00;
    {pause_n, wp_n} = 2'h3;
    {num_errors, checked, ws_n, sp_n, cyc} = '0;
    prev = 16'h0C00;
    tk(20);
    rst_n <= 1'b1;
    tk(4);
    chk("status", st, 8'h0C);
    chk("config", cf, 8'h00);
    chk("quad", qsp, 1'b0);
    bus_host_i.frame({`OP_WRITE_STATUS, 8'h00, 32'h0}, 2);
    cmd(`OP_LOCK_PROTECTION);
    chk("status", st, 8'h0C);
    chk("config", cf, 8'h00);
    chk("starts", ws_n, 0);
    busy <= 1'b1;
    tk(3);
    chk("busy", st, 8'h0D);
    busy <= 1'b0;
    $display("test reset and refusals done");
    for (int i = 0; i < 5; i++) begin
      wp_n <= ROWS[i][32];
      n0 = ws_n;
      write_status_cmd(ROWS[i][31:16]);
      chk("status", st, ROWS[i][15:8]);
      chk("config", cf, ROWS[i][7:0]);
      chk("starts", ws_n - n0, {31'h0, ROWS[i][15:0] != prev});
      prev = ROWS[i][15:0];
    end
    $display("test protection table done");
    wp_n <= 1'b1;
    cmd(`OP_WRITE_ENABLE);
    cmd(`OP_LOCK_PROTECTION);
    chk("config", cf, 8'h88);
    write_status_cmd(16'h0C88);
    chk("status", st, 8'h00);
    bus_host_i.frame({`OP_READ_CONFIG, 40'h0}, 2);
    chk("read", bus_host_i.rx, 8'h88);
    bus_host_i.select(1'b0);
    pause_n <= 1'b0;
    tk(6);
    chk("paused", paused, 1'b1);
    chk("oe", dq_oe, 4'h0);
    pause_n <= 1'b1;
    tk(6);
    chk("paused", paused, 1'b0);
    pause_n <= 1'b0;
    tk(6);
    bus_host_i.select(1'b1);
    tk(6);
    chk("paused", paused, 1'b0);
    pause_n <= 1'b1;
    bus_host_i.frame({`OP_READ_STATUS, 40'h0}, 2);
    chk("read", bus_host_i.rx, 8'h00);
    rst_n <= 1'b0;
    tk(2);
    rst_n <= 1'b1;
    tk(4);
    chk("config", cf, 8'h80);
    chk("status", st, 8'h0C);
    $display("test lock and pause done");
    write_status_cmd(16'h0C82);
    mode3 <= 1'b1;
    cmd(`OP_ENTER_QUAD);
    chk("quad", qsp, 1'b1);
    quad <= 1'b1;
    mode3 <= 1'b0;
    bus_host_i.frame({`OP_READ_CONFIG, 40'h0}, 2);
    chk("read", bus_host_i.rx, 8'h82);
    // the clock now rests low, so only the quad protocol keeps the pause out
    bus_host_i.select(1'b0);
    pause_n <= 1'b0;
    tk(6);
    chk("paused", paused, 1'b0);
    bus_host_i.select(1'b1);
    pause_n <= 1'b1;
    cmd(`OP_RESET_ENABLE);
    cmd(`OP_RESET_GO);
    quad <= 1'b0;
    chk("quad", qsp, 1'b0);
    chk("config", cf, 8'h80);
    $display("test quad done");
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        cmd(`OP_WRITE_ENABLE);
        cmd(`OP_LOCK_SECURE_ID);
        chk("idlock", sidl_nv, 1'b1);
      end
      n0 = sp_n;
      cmd(`OP_WRITE_ENABLE);
      bus_host_i.frame({`OP_PROGRAM_SECURE_ID, SIDS[i], 8'h5A, 8'h0}, 5);
      chk("progs", sp_n - n0, {31'h0, (i % 2 == 0) && (i < 3)});
      if (i == 2) chk("sid", {sadr, sdat}, {SIDS[i][10:0], 8'h5A});
    end
    $display("test security id done");
    wrap_up();
  end
endmodule : tb
